//--- core/sgfe_pkg.sv
// constants, descriptor layout and decode for the descriptor fetch engine
package sgfe_pkg;
   localparam int DSC_W = 256;
   localparam int DSC_BYTES = 32;
   localparam logic [15:0] DSC_MAGIC = 16'had4b;
   localparam int CTRL_STOP = 0;
   localparam int CTRL_DONE = 1;
   localparam int CTRL_EOP = 4;
   localparam int ADJ_W = 6;
   localparam int LEN_W = 28;
   localparam int FIFO_DEPTH = 512;
   localparam int MAX_READ_REQUEST_SIZE_BASE_DSC = 4;
   localparam logic [63:0] ADDR_NONE = 64'h0;

   typedef struct packed {
      logic [63:0] nxt;
      logic [63:0] dst;
      logic [63:0] src;
      logic [3:0] len_hi;
      logic [27:0] len;
      logic [15:0] magic;
      logic [1:0] rsv;
      logic [5:0] adj;
      logic [7:0] ctrl;
   } sgfe_dsc_t;

   // word 0 sits in the low 32 bits of the fetched beat
   function automatic sgfe_dsc_t sgfe_unpack(input logic [DSC_W-1:0] d);
      return sgfe_dsc_t'(d);
   endfunction : sgfe_unpack

   function automatic logic sgfe_magic_ok(input logic [DSC_W-1:0] d);
      sgfe_dsc_t x;
      x = sgfe_dsc_t'(d);
      return x.magic == DSC_MAGIC;
   endfunction : sgfe_magic_ok
endpackage : sgfe_pkg

//--- core/sgfe_dsc_fifo.sv
// shared descriptor FIFO held in flip-flops
`timescale 1ns/1ps
module sgfe_dsc_fifo #(
   parameter int W = 64,
   parameter int DEPTH = 512
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // write side
   input wire logic push,
   input wire logic [W-1:0] push_data,
   // read side
   input wire logic pop,
   output logic [W-1:0] rd_data,
   output logic empty,
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] cnt;
   } sgfe_fifo_t;
   sgfe_fifo_t s_ff, nxt_s;
   logic do_push, do_pop;

   always_comb begin
      nxt_s = s_ff;
      do_push = push && (s_ff.cnt < (AW+1)'(DEPTH));
      do_pop = pop && (s_ff.cnt != '0);
      if (do_push) begin
         nxt_s.mem[s_ff.wr_ptr] = push_data;
         nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;
      end
      if (do_pop) begin
         nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         nxt_s.cnt = s_ff.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         nxt_s.cnt = s_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign rd_data = s_ff.mem[s_ff.rd_ptr];
   assign empty = (s_ff.cnt == '0);
   assign count = s_ff.cnt;

   a_fifo_depth_bound: assert property (@(posedge clk) disable iff (sys_rst)
      s_ff.cnt <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule : sgfe_dsc_fifo

//--- core/sgfe_fetch_engine.sv
// scatter-gather descriptor fetch engine with per-channel lists
`timescale 1ns/1ps
module sgfe_fetch_engine #(
   parameter int NUM_CH = 2,
   parameter int DEPTH = sgfe_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // channel control from driver
   input wire logic [NUM_CH-1:0] ch_run,
   input wire logic [NUM_CH-1:0][63:0] ch_start_addr,
   input wire logic [NUM_CH-1:0][sgfe_pkg::ADJ_W-1:0] ch_first_adj,
   input wire logic [NUM_CH-1:0] ch_card_to_host,
   input wire logic stream_mode,
   input wire logic [2:0] max_read_request_size,
   input wire logic descriptor_done_irq_enable,
   // channel status
   output logic [NUM_CH-1:0] ch_stopped,
   output logic [NUM_CH-1:0] ch_error,
   // host read requests
   output logic rd_req_valid,
   input wire logic rd_req_ready,
   output logic [63:0] rd_req_addr,
   output logic [6:0] rd_req_count,
   output logic [(NUM_CH>1 ? $clog2(NUM_CH) : 1)-1:0] rd_req_ch,
   // host read completions, one descriptor per beat
   input wire logic cpl_valid,
   input wire logic [sgfe_pkg::DSC_W-1:0] cpl_data,
   // descriptors to the data mover
   output logic dsc_valid,
   input wire logic dsc_ready,
   output logic [(NUM_CH>1 ? $clog2(NUM_CH) : 1)-1:0] dsc_ch,
   output logic dsc_card_to_host,
   output logic [63:0] dsc_rd_addr,
   output logic [63:0] dsc_wr_addr,
   output logic [63:0] dsc_wb_addr,
   output logic [31:0] dsc_len,
   output logic dsc_packet_end,
   output logic dsc_irq_on_done,
   // completion from the data mover
   input wire logic xfer_done,
   input wire logic xfer_done_flagged,
   output logic desc_done_irq
);
   import sgfe_pkg::*;
   localparam int CHW = NUM_CH > 1 ? $clog2(NUM_CH) : 1;
   localparam int CW = $clog2(DEPTH) + 1;
   localparam int EW = CHW + 8 + LEN_W + 128;

   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_CPL} sgfe_st_t;
   typedef struct packed {
      sgfe_st_t st;
      logic [NUM_CH-1:0][63:0] addr;
      logic [NUM_CH-1:0][6:0] remain;
      logic [NUM_CH-1:0] live;
      logic [NUM_CH-1:0] fresh;
      logic [NUM_CH-1:0] stopped;
      logic [NUM_CH-1:0] err;
      logic [6:0] beats;
      logic req_valid;
      logic [63:0] req_addr;
      logic [6:0] req_count;
      logic [CHW-1:0] cur;
      logic req_first;
      logic out_valid;
      logic [CHW-1:0] out_ch;
      logic out_c2h;
      logic [63:0] out_rd;
      logic [63:0] out_wr;
      logic [63:0] out_wb;
      logic [31:0] out_len;
      logic out_eop;
      logic out_irq;
      logic irq;
   } sgfe_state_t;

   sgfe_state_t s_ff, nxt_s;
   sgfe_dsc_t dsc;
   logic push, pop, fifo_empty, found, ok;
   logic [EW-1:0] push_data, rd_data;
   logic [CW-1:0] fifo_count;
   logic [CHW-1:0] pick, e_ch;
   logic [7:0] e_ctrl;
   logic [LEN_W-1:0] e_len;
   logic [63:0] e_src, e_dst;
   int unsigned free_slots, lim, rem;

   sgfe_dsc_fifo #(.W(EW), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .push(push),
      .push_data(push_data),
      .pop(pop),
      .rd_data(rd_data),
      .empty(fifo_empty),
      .count(fifo_count)
   );

   assign dsc = sgfe_unpack(cpl_data);
   assign ok = sgfe_magic_ok(cpl_data);
   assign push_data = {s_ff.cur, dsc.ctrl, dsc.len, dsc.src, dsc.dst};
   assign {e_ch, e_ctrl, e_len, e_src, e_dst} = rd_data;

   always_comb begin
      nxt_s = s_ff;
      push = 1'b0;
      pop = 1'b0;
      found = 1'b0;
      pick = '0;
      free_slots = 0;
      lim = 0;
      rem = 0;
      // lowest runnable channel wins the fetch slot
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (s_ff.live[c] && !s_ff.stopped[c] && !s_ff.err[c] &&
             s_ff.remain[c] != 7'h0) begin
            found = 1'b1;
            pick = CHW'(c);
         end
      end
      for (int c = 0; c < NUM_CH; c++) begin
         if (!ch_run[c]) begin
            nxt_s.live[c] = 1'b0;
         end else if (!s_ff.live[c]) begin
            nxt_s.live[c] = 1'b1;
            nxt_s.fresh[c] = 1'b1;
            nxt_s.stopped[c] = 1'b0;
            nxt_s.err[c] = 1'b0;
            nxt_s.addr[c] = ch_start_addr[c];
            nxt_s.remain[c] = 7'(ch_first_adj[c]) + 7'h1;
         end
      end
      case (s_ff.st)
         ST_IDLE: begin
            free_slots = DEPTH - int'(fifo_count);
            lim = MAX_READ_REQUEST_SIZE_BASE_DSC << max_read_request_size;
            rem = int'(s_ff.remain[pick]);
            if (rem < lim) begin
               lim = rem;
            end
            if (free_slots < lim) begin
               lim = free_slots;
            end
            if (found && lim != 0) begin
               nxt_s.req_valid = 1'b1;
               nxt_s.req_addr = s_ff.addr[pick];
               nxt_s.req_count = 7'(lim);
               nxt_s.req_first = s_ff.fresh[pick];
               nxt_s.cur = pick;
               nxt_s.fresh[pick] = 1'b0;
               nxt_s.st = ST_REQ;
            end
         end
         ST_REQ: begin
            if (rd_req_ready) begin
               nxt_s.req_valid = 1'b0;
               nxt_s.beats = s_ff.req_count;
               nxt_s.st = ST_CPL;
            end
         end
         ST_CPL: begin
            if (cpl_valid) begin
               if (s_ff.live[s_ff.cur] && !s_ff.stopped[s_ff.cur] &&
                   !s_ff.err[s_ff.cur]) begin
                  if (!ok) begin
                     nxt_s.err[s_ff.cur] = 1'b1;
                  end else begin
                     push = 1'b1;
                     nxt_s.addr[s_ff.cur] = dsc.nxt;
                     if (dsc.ctrl[CTRL_STOP]) begin
                        nxt_s.stopped[s_ff.cur] = 1'b1;
                     end
                     if (s_ff.remain[s_ff.cur] == 7'h1) begin
                        nxt_s.remain[s_ff.cur] = 7'(dsc.adj) + 7'h1;
                     end else begin
                        nxt_s.remain[s_ff.cur] = s_ff.remain[s_ff.cur] - 7'h1;
                     end
                  end
               end
               nxt_s.beats = s_ff.beats - 7'h1;
               if (s_ff.beats == 7'h1) begin
                  nxt_s.st = ST_IDLE;
               end
            end
         end
         default: begin
            nxt_s.st = ST_IDLE;
         end
      endcase
      // output stage: addresses routed by direction in stream mode, no translation
      if (!s_ff.out_valid || dsc_ready) begin
         nxt_s.out_valid = !fifo_empty;
         pop = !fifo_empty;
         nxt_s.out_ch = e_ch;
         nxt_s.out_c2h = ch_card_to_host[e_ch];
         nxt_s.out_len = {4'h0, e_len};
         nxt_s.out_eop = e_ctrl[CTRL_EOP];
         nxt_s.out_irq = e_ctrl[CTRL_DONE];
         nxt_s.out_rd = (ch_card_to_host[e_ch] && stream_mode) ?
                        ADDR_NONE : e_src;
         nxt_s.out_wb = (ch_card_to_host[e_ch] && stream_mode) ?
                        e_src : ADDR_NONE;
         nxt_s.out_wr = (!ch_card_to_host[e_ch] && stream_mode) ?
                        ADDR_NONE : e_dst;
      end
      nxt_s.irq = xfer_done && xfer_done_flagged &&
                  descriptor_done_irq_enable;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign ch_stopped = s_ff.stopped;
   assign ch_error = s_ff.err;
   assign rd_req_valid = s_ff.req_valid;
   assign rd_req_addr = s_ff.req_addr;
   assign rd_req_count = s_ff.req_count;
   assign rd_req_ch = s_ff.cur;
   assign dsc_valid = s_ff.out_valid;
   assign dsc_ch = s_ff.out_ch;
   assign dsc_card_to_host = s_ff.out_c2h;
   assign dsc_rd_addr = s_ff.out_rd;
   assign dsc_wr_addr = s_ff.out_wr;
   assign dsc_wb_addr = s_ff.out_wb;
   assign dsc_len = s_ff.out_len;
   assign dsc_packet_end = s_ff.out_eop;
   assign dsc_irq_on_done = s_ff.out_irq;
   assign desc_done_irq = s_ff.irq;

   a_first_fetch_start: assert property (@(posedge clk) disable iff (sys_rst)
      rd_req_valid && s_ff.req_first |->
      rd_req_addr == ch_start_addr[rd_req_ch])
      else $error("first fetch not at start address");
   a_req_size_limit: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(rd_req_valid) |-> rd_req_count != 7'h0 &&
      int'(rd_req_count) <= (MAX_READ_REQUEST_SIZE_BASE_DSC << max_read_request_size) &&
      int'(rd_req_count) + int'(fifo_count) <= DEPTH)
      else $error("read request too large");
   a_block_reload: assert property (@(posedge clk) disable iff (sys_rst)
      s_ff.st == ST_CPL && cpl_valid && ok && s_ff.live[s_ff.cur] &&
      !s_ff.stopped[s_ff.cur] && !s_ff.err[s_ff.cur] &&
      s_ff.remain[s_ff.cur] == 7'h1 && ch_run[s_ff.cur] |=>
      s_ff.remain[$past(s_ff.cur)] == 7'($past(dsc.adj)) + 7'h1)
      else $error("block size not taken from follow count");
   a_stop_halts: assert property (@(posedge clk) disable iff (sys_rst)
      s_ff.stopped[s_ff.cur] && ch_run[s_ff.cur] && s_ff.live[s_ff.cur] |=>
      !($rose(rd_req_valid) && rd_req_ch == $past(s_ff.cur)))
      else $error("fetch after stop");
   a_bad_code_error: assert property (@(posedge clk) disable iff (sys_rst)
      s_ff.st == ST_CPL && cpl_valid && !ok && s_ff.live[s_ff.cur] &&
      ch_run[s_ff.cur] |=> ch_error[$past(s_ff.cur)] && !$past(push))
      else $error("bad validity code not flagged");
   a_len_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
      dsc_valid |-> dsc_len[31:28] == 4'h0)
      else $error("length upper bits set");
   a_stream_dst_unused: assert property (@(posedge clk) disable iff (sys_rst)
      dsc_valid && stream_mode && !dsc_card_to_host |->
      dsc_wr_addr == ADDR_NONE && dsc_wb_addr == ADDR_NONE)
      else $error("stream host-to-card used destination");
   a_done_irq_cause: assert property (@(posedge clk) disable iff (sys_rst)
      desc_done_irq |-> $past(xfer_done) && $past(xfer_done_flagged) &&
      $past(descriptor_done_irq_enable))
      else $error("done interrupt without cause");
   a_eop_carried: assert property (@(posedge clk) disable iff (sys_rst)
      dsc_valid && dsc_ready ##1 dsc_valid |->
      dsc_packet_end == $past(e_ctrl[CTRL_EOP]) || !$past(pop))
      else $error("packet end flag lost");
endmodule : sgfe_fetch_engine

//--- bench/sgfe_host_mem.sv
// host memory model that answers descriptor read requests
`timescale 1ns/1ps
module sgfe_host_mem (
   // clock
   input wire logic clk,
   // read requests
   input wire logic rd_req_valid,
   output logic rd_req_ready,
   input wire logic [63:0] rd_req_addr,
   input wire logic [6:0] rd_req_count,
   // completions, one descriptor per beat
   output logic cpl_valid,
   output logic [255:0] cpl_data,
   // answer delay in cycles
   input wire logic [1:0] lag
);
   logic [255:0] mem [logic [63:0]];
   logic [63:0] a;
   int n;
   initial begin
      rd_req_ready = 1'b0;
      cpl_valid = 1'b0;
      cpl_data = '0;
      forever begin
         @(negedge clk);
         if (rd_req_valid === 1'b1) begin
            repeat (lag) @(negedge clk);
            rd_req_ready = 1'b1;
            @(posedge clk);
            a = rd_req_addr;
            n = rd_req_count;
            @(negedge clk);
            rd_req_ready = 1'b0;
            repeat (lag) @(negedge clk);
            for (int i = 0; i < n; i++) begin
               cpl_valid = 1'b1;
               cpl_data = mem.exists(a) ? mem[a] : ~cpl_data;
               a = a + 64'h20;
               @(negedge clk);
            end
            cpl_valid = 1'b0;
            // released bus must not look like a stale descriptor
            cpl_data = ~cpl_data;
         end
      end
   end
endmodule : sgfe_host_mem

//--- bench/sgfe_fetch_engine_test.sv
// self-checking bench for the descriptor fetch engine
`timescale 1ns/1ps
module sgfe_fetch_engine_test;
   import sgfe_pkg::*;
   localparam int NCH = 2;
   localparam int DEP = 8;
   logic clk = 1'b0;
   logic sys_rst, stream_mode, descriptor_done_irq_enable;
   logic [NCH-1:0] ch_run, ch_card_to_host, ch_stopped, ch_error;
   logic [NCH-1:0][63:0] ch_start_addr;
   logic [NCH-1:0][5:0] ch_first_adj;
   logic [2:0] max_read_request_size;
   logic rd_req_valid, rd_req_ready, cpl_valid, dsc_valid;
   logic dsc_ready = 1'b0;
   logic [63:0] rd_req_addr, dsc_rd_addr, dsc_wr_addr, dsc_wb_addr;
   logic [6:0] rd_req_count;
   logic [0:0] rd_req_ch, dsc_ch;
   logic [255:0] cpl_data;
   logic dsc_card_to_host, dsc_packet_end, dsc_irq_on_done;
   logic [31:0] dsc_len;
   logic xfer_done, xfer_done_flagged, desc_done_irq;
   logic [1:0] lag;
   logic [226:0] exp_q [NCH][$];
   logic [63:0] nxt_a [NCH];
   int rem [NCH];
   logic done [NCH];
   logic fresh;
   int err_count = 0;
   int checks = 0;

   always #12.5 clk = ~clk;

   sgfe_fetch_engine #(.NUM_CH(NCH), .DEPTH(DEP)) u_sgfe_fetch_engine (
      .clk(clk), .sys_rst(sys_rst), .ch_run(ch_run),
      .ch_start_addr(ch_start_addr), .ch_first_adj(ch_first_adj),
      .ch_card_to_host(ch_card_to_host), .stream_mode(stream_mode),
      .max_read_request_size(max_read_request_size),
      .descriptor_done_irq_enable(descriptor_done_irq_enable),
      .ch_stopped(ch_stopped), .ch_error(ch_error),
      .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
      .rd_req_addr(rd_req_addr), .rd_req_count(rd_req_count),
      .rd_req_ch(rd_req_ch), .cpl_valid(cpl_valid), .cpl_data(cpl_data),
      .dsc_valid(dsc_valid), .dsc_ready(dsc_ready), .dsc_ch(dsc_ch),
      .dsc_card_to_host(dsc_card_to_host), .dsc_rd_addr(dsc_rd_addr),
      .dsc_wr_addr(dsc_wr_addr), .dsc_wb_addr(dsc_wb_addr),
      .dsc_len(dsc_len), .dsc_packet_end(dsc_packet_end),
      .dsc_irq_on_done(dsc_irq_on_done), .xfer_done(xfer_done),
      .xfer_done_flagged(xfer_done_flagged), .desc_done_irq(desc_done_irq));

   sgfe_host_mem u_host (
      .clk(clk), .rd_req_valid(rd_req_valid), .rd_req_ready(rd_req_ready),
      .rd_req_addr(rd_req_addr), .rd_req_count(rd_req_count),
      .cpl_valid(cpl_valid), .cpl_data(cpl_data), .lag(lag));

   task automatic print_verdict;
      if (err_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   task automatic chk_dsc(input logic [226:0] got, input logic [226:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: descriptor %h not %h", $time, got, exp);
      end
   endtask : chk_dsc

   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp,
         input string what);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask : chk_val

   // lay out one list in host memory and note what the mover should get
   task automatic build(input int c, input logic [63:0] base, input int bad);
      int sz [3];
      int nb, k;
      logic [63:0] a, nx, src, dst;
      logic [27:0] len;
      logic [7:0] f;
      logic [5:0] adj;
      logic d;
      nb = 1 + $urandom % 3;
      k = 0;
      d = ch_card_to_host[c];
      foreach (sz[i]) sz[i] = 1 + $urandom % 12;
      ch_first_adj[c] = 6'(sz[0] - 1);
      for (int b = 0; b < nb; b++) begin
         for (int j = 0; j < sz[b]; j++) begin
            a = base + 64'(b * 'h1000 + j * 32);
            src = {$urandom, $urandom};
            dst = {$urandom, $urandom};
            len = 28'($urandom);
            f = {3'h0, stream_mode & 1'($urandom), 2'h0, 1'($urandom), 1'b0};
            if (j < sz[b] - 1) begin
               adj = 6'(sz[b] - 2 - j);
               nx = a + 64'h20;
            end else begin
               adj = (b < nb - 1) ? 6'(sz[b + 1] - 1) : 6'h0;
               nx = (b < nb - 1) ? base + 64'((b + 1) * 'h1000) : 64'h0;
               f[0] = (b == nb - 1);
            end
            u_host.mem[a] = {nx, dst, src, 4'h0, len,
               (k == bad) ? ~DSC_MAGIC : DSC_MAGIC, 2'h0, adj, f};
            if (k < bad) exp_q[c].push_back({d,
               (stream_mode & d) ? 64'h0 : src,
               (stream_mode & ~d) ? 64'h0 : dst,
               (stream_mode & d) ? src : 64'h0,
               {4'h0, len}, f[4], f[1]});
            k++;
         end
      end
   endtask : build

   // every read request is checked against the walk of the list
   always @(posedge clk) begin : req_mon
      int c, lim, n;
      logic [255:0] dd;
      logic [63:0] a;
      if (sys_rst === 1'b0 && rd_req_valid === 1'b1 &&
            rd_req_ready === 1'b1) begin
         c = int'(rd_req_ch);
         n = int'(rd_req_count);
         lim = 4 << max_read_request_size;
         lim = (lim < rem[c]) ? lim : rem[c];
         lim = (lim < DEP) ? lim : DEP;
         chk_val(64'(done[c]), 64'h0, "fetch after end");
         chk_val(rd_req_addr, nxt_a[c], "fetch address");
         chk_val(64'(n >= 1 && n <= lim), 64'h1, "fetch size");
         if (c == 0 && fresh) chk_val(64'(n), 64'(lim), "size");
         if (c == 0) fresh = 1'b0;
         a = rd_req_addr;
         for (int i = 0; i < n && !done[c]; i++) begin
            dd = u_host.mem[a];
            a = a + 64'h20;
            rem[c]--;
            nxt_a[c] = dd[255:192];
            if (dd[31:16] !== DSC_MAGIC) done[c] = 1'b1;
            else if (rem[c] == 0 && dd[0]) done[c] = 1'b1;
            else if (rem[c] == 0) rem[c] = int'(dd[13:8]) + 1;
         end
      end
   end

   always @(posedge clk) begin : dsc_mon
      logic [226:0] e;
      if (sys_rst === 1'b0 && dsc_valid === 1'b1 && dsc_ready === 1'b1) begin
         e = 'x;
         if (dsc_ch !== 1'bx && exp_q[dsc_ch].size() > 0)
            e = exp_q[dsc_ch].pop_front();
         chk_dsc({dsc_card_to_host, dsc_rd_addr, dsc_wr_addr, dsc_wb_addr,
            dsc_len, dsc_packet_end, dsc_irq_on_done}, e);
      end
   end

   // the mover stalls on about a quarter of the cycles
   always @(negedge clk) dsc_ready <= ($urandom % 4) != 0;

   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h5279dc90));
      sys_rst = 1'b1;
      ch_run = '0;
      ch_card_to_host = '0;
      ch_start_addr = '0;
      ch_first_adj = '0;
      stream_mode = 1'b0;
      max_read_request_size = 3'h0;
      descriptor_done_irq_enable = 1'b0;
      xfer_done = 1'b0;
      xfer_done_flagged = 1'b0;
      lag = 2'h0;
      fresh = 1'b0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      chk_val(64'({rd_req_valid, dsc_valid, ch_stopped, desc_done_irq}),
         64'h0, "idle after reset");
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         descriptor_done_irq_enable = i[0];
         xfer_done_flagged = i[1];
         xfer_done = 1'b1;
         @(negedge clk);
         xfer_done = 1'b0;
         chk_val(64'(desc_done_irq), 64'(i == 3), "done irq");
         @(negedge clk);
         chk_val(64'(desc_done_irq), 64'h0, "done irq pulse");
      end
      for (int s = 0; s < 6; s++) begin
         @(negedge clk);
         max_read_request_size = 3'(s);
         stream_mode = s[0];
         descriptor_done_irq_enable = 1'b1;
         lag = 2'($urandom);
         for (int c = 0; c < NCH; c++) begin
            ch_card_to_host[c] = 1'($urandom);
            ch_start_addr[c] = 64'h1_0000_0000 * (s + 1) + 64'h10_0000 * c;
            build(c, ch_start_addr[c], (s == 4 && c == 1) ? 0 : 999);
            nxt_a[c] = ch_start_addr[c];
            rem[c] = int'(ch_first_adj[c]) + 1;
            done[c] = 1'b0;
         end
         fresh = 1'b1;
         ch_run = '1;
         repeat (2) @(negedge clk);
         chk_val(64'({ch_stopped, ch_error}), 64'h0, "cleared");
         for (int t = 0; t < 3000; t++) begin
            if ((ch_stopped | ch_error) === 2'b11 && exp_q[0].size() == 0 &&
                  exp_q[1].size() == 0) break;
            @(negedge clk);
         end
         chk_val(64'(ch_stopped), (s == 4) ? 64'h1 : 64'h3, "stopped");
         chk_val(64'(ch_error), (s == 4) ? 64'h2 : 64'h0, "error");
         ch_run = '0;
         repeat (4) @(negedge clk);
      end
      print_verdict();
   end
endmodule : sgfe_fetch_engine_test
